// ==== rtl/ddr_burst4_sram_bus.sv ====
// burst-of-four ddr sram bus: capture, posted writes, read bypass, launch,
// echo clocks and background impedance calibration
// assumes the master owns both clock pairs and keeps its turnaround rules
//
// Functional notes
// RULE1: a 2-bit burst counter walks four beats, linear order only.
// RULE2: low burst address bits step on every rising edge of both clocks.
// RULE3: address, data, load and direction are captured by the input pair.
// RULE4: write data taken on true and complement rising edges.
// RULE5: read data launched by output pair, or input pair when held high.
// RULE6: every transfer is exactly four words; no other length exists.
// RULE7: master leaves one or two idle slots between read and write.
// RULE8: a read may follow a write with no idle slot.
// RULE9: a write followed by reads stays in holding registers.
// RULE10: next write commits the held write into the array.
// RULE11: read of a held address returns held data, bypassing the array.
// RULE12: address compare only while a write is held and a read runs.
// RULE13: power-up drive code is default; calibrated after 1024 cycles.
// RULE14: drive code updates never disturb a transfer in progress.
// RULE15: echo clocks follow the data launch path, in antiphase.
// RULE16: launch clock rising makes echo true rise and echo comp fall.
// RULE17: echo true rising marks the first word of a read.
// RULE18: echo clocks are always driven, never released.
// RULE19: master holds output clock pair high when not supplying it.
// RULE20: no loop lock; stopped clocks resume with no restart.
// RULE21: fast masters should capture read data on the echo clocks.
// RULE22: master drives load low with address and direction per transfer.
// RULE23: low byte write enable writes its lane on each of four beats.
// RULE24: words two and four on comp edges, one and three on true edges.
// RULE25: address and control only on true edge; data on both edges.
// RULE26: direction high with load low is read, low is write.
`timescale 1ns/1ps
module ddr_burst4_sram_bus
	import ddr_burst4_sram_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic                  input_clock_true,
	input  wire logic                  input_clock_comp,
	input  wire logic                  output_clock_true,
	input  wire logic                  output_clock_comp,
	input  wire logic                  load_n,
	input  wire logic                  read_write_sel,
	input  wire logic [ROW_W-1:0]      sync_address,
	input  wire logic                  burst_addr_bit_lo,
	input  wire logic                  burst_addr_bit_hi,
	input  wire logic [LANES-1:0]      byte_write_n,
	input  wire logic [DATA_W-1:0]     data_in,
	output logic      [DATA_W-1:0]     data_out,
	output logic                       data_oe,
	output logic                       echo_clock_true,
	output logic                       echo_clock_comp,
	input  wire logic                  impedance_ref_pin,
	output logic      [IMP_CODE_W-1:0] drive_code,
	output logic                       impedance_calibrated
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [DATA_W-1:0]     mem [2**MEM_AW];
	logic                  link_rst_meta_reg;
	logic                  link_rstn_reg;
	logic                  zq_meta_reg;
	logic                  zq_sync_reg;
	logic                  oclk_meta_reg;
	logic                  oclk_sync_reg;
	logic                  oclk_seen_reg;
	logic                  used_meta_reg;
	logic                  out_clk_used_reg;
	logic [CAL_CNT_W-1:0]  cal_cnt_reg;
	logic                  cal_done_reg;
	logic [RESAMPLE_W-1:0] samp_cnt_reg;
	logic [IMP_CODE_W-1:0] imp_code_reg;
	logic [IMP_CODE_W-1:0] sent_code_reg;
	logic                  imp_ready;
	logic                  imp_valid;
	logic [IMP_CODE_W-1:0] imp_data;
	logic                  imp_pend_reg;
	logic [IMP_CODE_W-1:0] imp_new_reg;
	logic [IMP_CODE_W-1:0] drive_code_reg;
	link_state_t           state_reg;
	logic [DATA_W-1:0]     comp_data_reg;
	logic [LANES-1:0]      comp_be_reg;
	logic [ROW_W-1:0]      wr_addr_reg;
	logic [BURST_W-1:0]    wr_start_reg;
	logic [DATA_W-1:0]     wbuf_reg [BURST_LEN-1];
	logic [LANES-1:0]      wbe_reg [BURST_LEN-1];
	logic [DATA_W-1:0]     beat_data [BURST_LEN];
	logic [LANES-1:0]      beat_be [BURST_LEN];
	logic                  wr_finish_reg;
	logic                  hold_pend_reg;
	logic [ROW_W-1:0]      hold_addr_reg;
	logic [DATA_W-1:0]     hold_data_reg [BURST_LEN];
	logic [LANES-1:0]      hold_be_reg [BURST_LEN];
	logic [ROW_W-1:0]      rd_addr_reg;
	logic [BURST_W-1:0]    rd_start_reg;
	logic [DATA_W-1:0]     rd_buf_reg [BURST_LEN];
	logic [BURST_W-1:0]    wr_idx [BURST_LEN];
	logic [BURST_W-1:0]    rd_idx [BURST_LEN];
	logic [1:0]            out_phase_reg;
	logic                  cmd_take;
	logic                  cmd_read;
	logic                  rd_hit;
	logic                  link_quiet;
	logic                  commit_en;
	logic                  launch_true;
	logic                  launch_comp;
	logic [DATA_W-1:0]     q_true_reg;
	logic [DATA_W-1:0]     q_stage_reg;
	logic                  oe_true_reg;
	logic [DATA_W-1:0]     q_comp_reg;
	logic                  oe_comp_reg;
	logic [DATA_W-1:0]     byp_word0;
	logic [DATA_W-1:0]     array_word0;

	// write lane merge of held data over an array word on a bypass hit
	function automatic logic [DATA_W-1:0] merge_word(
		input logic [DATA_W-1:0] arr,
		input logic [DATA_W-1:0] held,
		input logic [LANES-1:0]  be_n,
		input logic              hit);
		logic [DATA_W-1:0] w;
		w = arr;
		for (int l = 0; l < LANES; l++) begin
			if (hit && !be_n[l])
				w[l*LANE_W +: LANE_W] = held[l*LANE_W +: LANE_W];
		end
		return w;
	endfunction

	// ---------------------------------------------------------------
	// system clock side: synchronisers and impedance calibration
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		zq_meta_reg   <= impedance_ref_pin;
		zq_sync_reg   <= zq_meta_reg;
		oclk_meta_reg <= output_clock_true;
		oclk_sync_reg <= oclk_meta_reg;
	end

	// any low seen on the output clock means the master supplies it
	always_ff @(posedge clk) begin
		if (!rstn)
			oclk_seen_reg <= 1'b0;
		else if (!oclk_sync_reg)
			oclk_seen_reg <= 1'b1; // RULE19
	end

	// power-up window; transfers are allowed before it ends
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cal_cnt_reg  <= '0;
			cal_done_reg <= 1'b0;
		end else if (cal_cnt_reg != CAL_DONE_CNT) begin
			cal_cnt_reg  <= cal_cnt_reg + 1'b1; // RULE13
			cal_done_reg <= cal_cnt_reg == CAL_DONE_CNT - 1'b1;
		end
	end

	// step every cycle while calibrating, then once per resample period
	always_ff @(posedge clk) begin
		if (!rstn) begin
			samp_cnt_reg <= '0;
			imp_code_reg <= IMP_CODE_RESET; // RULE13
		end else begin
			samp_cnt_reg <= samp_cnt_reg + 1'b1;
			if (!cal_done_reg || samp_cnt_reg == RESAMPLE_LAST) begin
				if (zq_sync_reg && imp_code_reg != IMP_CODE_MAX)
					imp_code_reg <= imp_code_reg + 1'b1; // RULE14
				else if (!zq_sync_reg && imp_code_reg != IMP_CODE_MIN)
					imp_code_reg <= imp_code_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			sent_code_reg <= IMP_CODE_RESET;
		else if (imp_ready && imp_code_reg != sent_code_reg)
			sent_code_reg <= imp_code_reg;
	end

	assign impedance_calibrated = cal_done_reg;

	word_handshake_sync u_code_sync (
		.src_clk   (clk),
		.src_rstn  (rstn),
		.src_valid (imp_code_reg != sent_code_reg),
		.src_data  (imp_code_reg),
		.src_ready (imp_ready),
		.dst_clk   (input_clock_true),
		.dst_rstn  (link_rstn_reg),
		.dst_valid (imp_valid),
		.dst_data  (imp_data)
	);

	// ---------------------------------------------------------------
	// link side: reset, command capture, burst sequencing
	// ---------------------------------------------------------------
	// nothing here needs a loop lock, so a stopped clock just freezes it
	always_ff @(posedge input_clock_true) begin // RULE20
		link_rst_meta_reg <= rstn;
		link_rstn_reg     <= link_rst_meta_reg;
		used_meta_reg     <= oclk_seen_reg;
		out_clk_used_reg  <= used_meta_reg;
	end

	assign cmd_take = state_reg == LINK_IDLE && !load_n; // RULE22 RULE25
	assign cmd_read = read_write_sel == RW_READ; // RULE26

	// commands only on every other true edge: a transfer is two periods
	always_ff @(posedge input_clock_true) begin
		if (!link_rstn_reg) begin
			state_reg <= LINK_IDLE;
		end else begin
			case (state_reg)
				LINK_IDLE: begin
					if (cmd_take)
						state_reg <= cmd_read ? LINK_RD2 : LINK_WR2; // RULE6
				end
				LINK_WR2: state_reg <= LINK_IDLE;
				LINK_RD2: state_reg <= LINK_IDLE; // RULE8
				default:  state_reg <= LINK_IDLE;
			endcase
		end
	end

	// complement edge takes beats two and four of a write
	always_ff @(posedge input_clock_comp) begin // RULE4
		comp_data_reg <= data_in;
		comp_be_reg   <= byte_write_n;
	end

	always_ff @(posedge input_clock_true) begin // RULE3 RULE25
		if (cmd_take && !cmd_read) begin
			wr_addr_reg  <= sync_address;
			wr_start_reg <= {burst_addr_bit_hi, burst_addr_bit_lo};
			wbuf_reg[0]  <= data_in;
			wbe_reg[0]   <= byte_write_n;
		end
		if (state_reg == LINK_WR2) begin
			wbuf_reg[1] <= comp_data_reg;
			wbe_reg[1]  <= comp_be_reg;
			wbuf_reg[2] <= data_in;
			wbe_reg[2]  <= byte_write_n; // RULE23
		end
	end

	always_comb begin
		beat_data[0] = wbuf_reg[0];
		beat_data[1] = wbuf_reg[1];
		beat_data[2] = wbuf_reg[2];
		beat_data[3] = comp_data_reg;
		beat_be[0]   = wbe_reg[0];
		beat_be[1]   = wbe_reg[1];
		beat_be[2]   = wbe_reg[2];
		beat_be[3]   = comp_be_reg;
	end

	// burst counter: beat b lands on start + b, wrapping in two bits
	for (genvar g = 0; g < BURST_LEN; g++) begin : g_burst
		assign wr_idx[g] = burst_index(wr_start_reg, BURST_W'(g)); // RULE1
		assign rd_idx[g] = burst_index(rd_start_reg, BURST_W'(g)); // RULE2
	end

	// ---------------------------------------------------------------
	// posted write: hold, commit on the next write, read bypass
	// ---------------------------------------------------------------
	// every write parks in the hold registers; the array only sees it when
	// the next write finishes, so reads never collide with an array write
	always_ff @(posedge input_clock_true) begin
		if (!link_rstn_reg) begin
			wr_finish_reg <= 1'b0;
			hold_pend_reg <= 1'b0;
		end else begin
			wr_finish_reg <= state_reg == LINK_WR2;
			if (wr_finish_reg) begin
				hold_pend_reg <= 1'b1; // RULE9
				hold_addr_reg <= wr_addr_reg;
				for (int b = 0; b < BURST_LEN; b++) begin
					hold_data_reg[wr_idx[b]] <= beat_data[b];
					hold_be_reg[wr_idx[b]]   <= beat_be[b];
				end
			end
		end
	end

	assign commit_en = link_rstn_reg && wr_finish_reg && hold_pend_reg;

	always_ff @(posedge input_clock_true) begin // RULE10
		if (commit_en) begin
			for (int i = 0; i < BURST_LEN; i++) begin
				for (int l = 0; l < LANES; l++) begin
					if (!hold_be_reg[i][l]) // RULE23
						mem[{hold_addr_reg, BURST_W'(i)}][l*LANE_W +: LANE_W]
							<= hold_data_reg[i][l*LANE_W +: LANE_W];
				end
			end
		end
	end

	// row compare, burst bits excluded, only during a read's second cycle
	assign rd_hit = state_reg == LINK_RD2 && hold_pend_reg
		&& rd_addr_reg == hold_addr_reg; // RULE12

	always_ff @(posedge input_clock_true) begin
		if (cmd_take && cmd_read) begin
			rd_addr_reg  <= sync_address;
			rd_start_reg <= {burst_addr_bit_hi, burst_addr_bit_lo};
		end
		if (state_reg == LINK_RD2) begin
			for (int i = 0; i < BURST_LEN; i++) begin
				rd_buf_reg[i] <= merge_word(mem[{rd_addr_reg, rd_idx[i]}],
					hold_data_reg[rd_idx[i]], hold_be_reg[rd_idx[i]],
					rd_hit); // RULE11
			end
		end
	end

	always_ff @(posedge input_clock_true) begin
		if (!link_rstn_reg)
			out_phase_reg <= OUT_NONE;
		else if (state_reg == LINK_RD2)
			out_phase_reg <= OUT_FIRST;
		else if (out_phase_reg == OUT_FIRST)
			out_phase_reg <= OUT_SECOND;
		else
			out_phase_reg <= OUT_NONE;
	end

	// ---------------------------------------------------------------
	// drive code update, held off while any transfer is in flight
	// ---------------------------------------------------------------
	assign link_quiet = state_reg == LINK_IDLE && load_n && !wr_finish_reg
		&& out_phase_reg == OUT_NONE;

	// a code arriving in the apply cycle stays pending, it is not lost
	always_ff @(posedge input_clock_true) begin
		if (!link_rstn_reg) begin
			imp_pend_reg   <= 1'b0;
			drive_code_reg <= IMP_CODE_RESET;
		end else begin
			if (link_quiet && imp_pend_reg) begin
				drive_code_reg <= imp_new_reg; // RULE14
				imp_pend_reg   <= 1'b0;
			end
			if (imp_valid) begin
				imp_pend_reg <= 1'b1;
				imp_new_reg  <= imp_data;
			end
		end
	end

	assign drive_code = drive_code_reg;

	// ---------------------------------------------------------------
	// read launch and echo clocks
	// ---------------------------------------------------------------
	// the mux moves once, when the output clock is first seen low; reads before the output clock
	// is adopted may see one short launch phase
	assign launch_true = out_clk_used_reg ? output_clock_true
		: input_clock_true; // RULE5
	assign launch_comp = out_clk_used_reg ? output_clock_comp
		: input_clock_comp;

	always_ff @(posedge launch_true) begin // RULE24
		if (!link_rstn_reg) begin
			oe_true_reg <= 1'b0;
			q_true_reg  <= '0;
			q_stage_reg <= '0;
		end else begin
			case (out_phase_reg)
				OUT_FIRST: begin
					oe_true_reg <= 1'b1; // RULE17
					q_true_reg  <= rd_buf_reg[0];
					q_stage_reg <= rd_buf_reg[1];
				end
				OUT_SECOND: begin
					oe_true_reg <= 1'b1;
					q_true_reg  <= rd_buf_reg[2];
					q_stage_reg <= rd_buf_reg[3];
				end
				default: oe_true_reg <= 1'b0;
			endcase
		end
	end

	// comp launch only reads true-launch flops, never the read buffer
	always_ff @(posedge launch_comp) begin // RULE24
		if (!link_rstn_reg) begin
			oe_comp_reg <= 1'b0;
			q_comp_reg  <= '0;
		end else begin
			oe_comp_reg <= oe_true_reg;
			q_comp_reg  <= q_stage_reg;
		end
	end

	// device drives only after a read; master must leave idle slots
	assign data_out = launch_true ? q_true_reg : q_comp_reg;
	assign data_oe  = launch_true ? oe_true_reg : oe_comp_reg; // RULE7

	// same launch clock as the data, complement in antiphase, no enable
	assign echo_clock_true = launch_true; // RULE15 RULE16 RULE18
	assign echo_clock_comp = ~launch_true; // RULE15 RULE16

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	assign byp_word0   = hold_data_reg[rd_idx[0]];
	assign array_word0 = mem[{rd_addr_reg, rd_idx[0]}];

	sequence write_take_s;
		state_reg == LINK_IDLE && !load_n && read_write_sel != RW_READ;
	endsequence

	sequence write_second_s;
		state_reg == LINK_WR2;
	endsequence

	burst_shape_a: assert property ( // RULE6
		@(posedge input_clock_true) disable iff (!link_rstn_reg)
		write_take_s |=> write_second_s ##1 wr_finish_reg)
		else $error("write burst did not span two periods");

	read_after_write_a: assert property ( // RULE8
		@(posedge input_clock_true) disable iff (!link_rstn_reg)
		write_second_s ##1 (!load_n && read_write_sel == RW_READ)
		|=> state_reg == LINK_RD2)
		else $error("read right after write was not taken");

	hold_stable_a: assert property ( // RULE9
		@(posedge input_clock_true) disable iff (!link_rstn_reg)
		(hold_pend_reg && !wr_finish_reg) |=> $stable(hold_addr_reg))
		else $error("held write address moved without a write");

	commit_next_a: assert property ( // RULE10
		@(posedge input_clock_true) disable iff (!link_rstn_reg)
		wr_finish_reg |=> hold_pend_reg
		&& hold_addr_reg == $past(wr_addr_reg))
		else $error("finished write not parked for commit");

	bypass_word_a: assert property ( // RULE11
		@(posedge input_clock_true) disable iff (!link_rstn_reg)
		(rd_hit && hold_be_reg[rd_idx[0]] == {LANES{1'b0}})
		|=> rd_buf_reg[0] == $past(byp_word0))
		else $error("read of held address missed the bypass");

	compare_gate_a: assert property ( // RULE12
		@(posedge input_clock_true) disable iff (!link_rstn_reg)
		(state_reg == LINK_RD2 && !rd_hit)
		|=> rd_buf_reg[0] == $past(array_word0))
		else $error("read that missed the held write did not use array");

	burst_linear_a: assert property ( // RULE1
		@(posedge input_clock_true) disable iff (!link_rstn_reg)
		wr_finish_reg
		|=> hold_data_reg[$past(wr_idx[1])] == $past(beat_data[1]))
		else $error("second beat not at start plus one");

	drive_quiet_a: assert property ( // RULE14
		@(posedge input_clock_true) disable iff (!link_rstn_reg)
		$changed(drive_code_reg) |-> $past(link_quiet))
		else $error("drive code changed during a transfer");

	clk_sel_sticky_a: assert property ( // RULE5
		@(posedge input_clock_true) disable iff (!link_rstn_reg)
		out_clk_used_reg |=> out_clk_used_reg)
		else $error("output clock selection fell back");

	first_word_a: assert property ( // RULE17
		@(posedge launch_true) disable iff (!link_rstn_reg)
		out_phase_reg == OUT_FIRST
		|=> oe_true_reg && q_true_reg == $past(rd_buf_reg[0]))
		else $error("first read word not on echo true rising");

	cal_early_a: assert property ( // RULE13
		@(posedge clk) disable iff (!rstn)
		(cal_cnt_reg != CAL_DONE_CNT) |-> !cal_done_reg)
		else $error("calibration reported before its window ended");

endmodule // ddr_burst4_sram_bus

// ==== rtl/ddr_burst4_sram_pkg.sv ====
// constants, state encoding and burst decoding for the burst-of-four sram bus
// assumes the x18 arrangement: 18 data bits in two 9-bit byte lanes
package ddr_burst4_sram_pkg;

	// ---------------------------------------------------------------
	// array and bus shape
	// ---------------------------------------------------------------
	localparam int DATA_W    = 18;
	localparam int LANE_W    = 9;
	localparam int LANES     = 2;
	localparam int ROW_W     = 18; // address above the burst pair
	localparam int BURST_W   = 2;
	localparam int BURST_LEN = 4;
	localparam int MEM_AW    = ROW_W + BURST_W;
	localparam logic RW_READ = 1'b1;

	// ---------------------------------------------------------------
	// read launch phases
	// ---------------------------------------------------------------
	localparam logic [1:0] OUT_NONE   = 2'h0;
	localparam logic [1:0] OUT_FIRST  = 2'h1;
	localparam logic [1:0] OUT_SECOND = 2'h2;

	// ---------------------------------------------------------------
	// impedance calibration
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CAL_CYCLES    = 1024;
	localparam int CAL_CNT_W     = 11;
	localparam logic [CAL_CNT_W-1:0] CAL_DONE_CNT = 11'h400;
	localparam int IMP_CODE_W    = 6;
	localparam logic [IMP_CODE_W-1:0] IMP_CODE_RESET = 6'h20;
	localparam logic [IMP_CODE_W-1:0] IMP_CODE_MAX   = 6'h3F;
	localparam logic [IMP_CODE_W-1:0] IMP_CODE_MIN   = 6'h00;
	localparam int RESAMPLE_W = 8;
	localparam logic [RESAMPLE_W-1:0] RESAMPLE_LAST = 8'hFF;

	typedef enum logic [1:0] {LINK_IDLE, LINK_WR2, LINK_RD2} link_state_t;

	// linear burst order: the beat is added to the start, wrapping in 2 bits
	function automatic logic [BURST_W-1:0] burst_index(
		input logic [BURST_W-1:0] start,
		input logic [BURST_W-1:0] beat);
		return BURST_W'(start + beat);
	endfunction

endpackage

// ==== rtl/word_handshake_sync.sv ====
// toggle handshake that carries one word from a source to a destination clock
// assumes src_data is only offered while src_ready is high
`timescale 1ns/1ps
module word_handshake_sync
	import ddr_burst4_sram_pkg::*;
(
	input  wire logic                  src_clk,
	input  wire logic                  src_rstn,
	input  wire logic                  src_valid,
	input  wire logic [IMP_CODE_W-1:0] src_data,
	output logic                       src_ready,
	input  wire logic                  dst_clk,
	input  wire logic                  dst_rstn,
	output logic                       dst_valid,
	output logic [IMP_CODE_W-1:0]      dst_data
);

	logic                  req_reg;
	logic                  busy_reg;
	logic [IMP_CODE_W-1:0] hold_reg;
	logic                  ack_meta_reg;
	logic                  ack_sync_reg;
	logic                  req_meta_reg;
	logic                  req_sync_reg;
	logic                  ack_reg;

	// ---------------------------------------------------------------
	// source side
	// ---------------------------------------------------------------
	// word stays frozen in hold_reg until the ack returns
	always_ff @(posedge src_clk) begin
		if (!src_rstn) begin
			req_reg  <= 1'b0;
			busy_reg <= 1'b0;
			hold_reg <= IMP_CODE_RESET;
		end else if (src_valid && !busy_reg) begin
			req_reg  <= ~req_reg;
			busy_reg <= 1'b1;
			hold_reg <= src_data;
		end else if (busy_reg && ack_sync_reg == req_reg) begin
			busy_reg <= 1'b0;
		end
	end

	always_ff @(posedge src_clk) begin
		ack_meta_reg <= ack_reg;
		ack_sync_reg <= ack_meta_reg;
	end

	assign src_ready = !busy_reg;

	// ---------------------------------------------------------------
	// destination side
	// ---------------------------------------------------------------
	always_ff @(posedge dst_clk) begin
		req_meta_reg <= req_reg;
		req_sync_reg <= req_meta_reg;
	end

	// a toggle seen on the synced request means a new stable word
	always_ff @(posedge dst_clk) begin
		if (!dst_rstn) begin
			ack_reg   <= 1'b0;
			dst_valid <= 1'b0;
			dst_data  <= IMP_CODE_RESET;
		end else begin
			dst_valid <= req_sync_reg != ack_reg;
			if (req_sync_reg != ack_reg) begin
				ack_reg  <= req_sync_reg;
				dst_data <= hold_reg;
			end
		end
	end

endmodule // word_handshake_sync

// ==== sim/burst_master_model.sv ====
// master model: input clock pair and four-beat commands
// assumes callers start a command just after a clock pair edge
`timescale 1ns/1ps
module burst_master_model
	import ddr_burst4_sram_pkg::*;
(
	output logic              kt,
	output logic              kc,
	output logic              load_n,
	output logic              rws,
	output logic [ROW_W-1:0]  row,
	output logic [1:0]        st,
	output logic [LANES-1:0]  be_n,
	output logic [DATA_W-1:0] din
);
	// 80 ns pair, offset 3 ns so it never lines up with clk
	initial begin
		{rws, row, st, be_n, din} = '0;
		{kt, kc, load_n} = 3'b011;
		#3;
		forever #40 {kt, kc} = {kc, kt};
	end
	// one command; beats go out on true, comp, true, comp edges
	task automatic cmd(logic rd, logic [ROW_W-1:0] r, logic [1:0] s,
		logic [4*DATA_W-1:0] d, logic [7:0] b);
		{load_n, rws, row, st} = {1'b0, rd, r, s};
		for (int i = 0; i < 4; i++) begin
			{din, be_n} = {d[i*DATA_W +: DATA_W], b[i*2 +: 2]};
			if (i[0]) begin
				@(posedge kc);
			end else begin
				@(posedge kt);
			end
			#2;
			// released address must not keep the old value
			if (i == 0)
				{load_n, row} = {1'b1, ~row};
		end
	endtask
	// idle slot for read to write turnaround; stale data is inverted
	task automatic nop();
		din = ~din;
		@(posedge kt) #2;
	endtask
endmodule // burst_master_model

// ==== sim/test_ddr_burst4_sram_bus.sv ====
// self-checking bench for the burst-of-four sram bus
// assumes the master model drives every link input of the block
`timescale 1ns/1ps
module test_ddr_burst4_sram_bus
	import ddr_burst4_sram_pkg::*;
();
	logic clk, rstn, zq, kt, kc, ld, rws, oe, eqt, eqc, cal;
	logic [ROW_W-1:0]      row;
	logic [1:0]            st, be;
	logic [DATA_W-1:0]     din, dout;
	logic [IMP_CODE_W-1:0] code;
	logic [DATA_W-1:0]     mem [int];
	logic [DATA_W-1:0]     exq [$];
	int                    rd_at [$];
	int n_errors = 0, total_checks = 0, ke = 0, cyc = 0, rel = 0;
	bit                    last_rd = 0;
	bit                    oc_on = 0;
	burst_master_model m (.kt(kt), .kc(kc), .load_n(ld), .rws(rws),
		.row(row), .st(st), .be_n(be), .din(din));
	// output clock pair held high until oc_on, then a copy of the input pair
	ddr_burst4_sram_bus uut (.clk(clk), .rstn(rstn), .input_clock_true(kt),
		.input_clock_comp(kc),
		.output_clock_true(oc_on ? kt : 1'b1),
		.output_clock_comp(oc_on ? kc : 1'b1),
		.load_n(ld), .read_write_sel(rws),
		.sync_address(row), .burst_addr_bit_lo(st[0]),
		.burst_addr_bit_hi(st[1]), .byte_write_n(be), .data_in(din),
		.data_out(dout), .data_oe(oe), .echo_clock_true(eqt),
		.echo_clock_comp(eqc), .impedance_ref_pin(zq), .drive_code(code),
		.impedance_calibrated(cal));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// hang guard; the tests need about 1100 cycles
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			wrap_up();
		end
	end
	always @(negedge clk) zq <= 1'($urandom);
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		total_checks++;
		if (e !== s) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// sample mid-way through each half period, as an echo-timed receiver
	task automatic rd_check();
		for (int i = 0; i < 4; i++) begin
			#20;
			chk("data_out", exq.pop_front(), dout);
			chk("data_oe", 1'b1, oe);
			chk("echo", {!i[0], i[0]}, {eqt, eqc});
			#20;
		end
	endtask
	// reads launch two link periods after their command edge
	always @(posedge kt) begin
		ke = ke + 1;
		if (rd_at.size() != 0 && rd_at[0] == ke) begin
			void'(rd_at.pop_front());
			fork
				rd_check();
			join_none
		end
	end
	// one transfer; the reference array is updated lane by lane
	task automatic op(logic rd, logic [ROW_W-1:0] r, logic [1:0] s, bit full);
		logic [4*DATA_W-1:0] d;
		logic [7:0]          b;
		int                  a;
		d = 72'({$urandom, $urandom, $urandom});
		b = full ? 8'h00 : 8'($urandom);
		if (last_rd && !rd)
			repeat (2) m.nop();
		if (rd)
			rd_at.push_back(ke + 3);
		for (int i = 0; i < 4; i++) begin
			a = {r, 2'(s + i)};
			for (int j = 0; j < LANES; j++) begin
				if (!rd && !b[i*2+j])
					mem[a][j*LANE_W +: LANE_W] = d[i*DATA_W+j*LANE_W +: LANE_W];
			end
			if (rd)
				exq.push_back(mem[a]);
		end
		m.cmd(rd, r, s, d, b);
		last_rd = rd;
	endtask
	initial begin
		void'($urandom(24));
		rstn = 1'b0;
		// reset spans three link periods so the link side takes it
		repeat (3) @(posedge kt);
		#2;
		chk("drive_code", IMP_CODE_RESET, code);
		chk("calibrated", 1'b0, cal);
		@(negedge clk) rstn = 1;
		rel = cyc;
		fork
			begin
				wait (cyc == rel + 1023);
				#1 chk("cal_early", 1'b0, cal);
				@(posedge clk) #1 chk("cal_on_time", 1'b1, cal);
			end
		join_none
		repeat (3) @(posedge kt);
		#2;
		for (int r = 0; r < 4; r++)
			op(0, ROW_W'(r), 2'(r), 1);
		$display("test fill done");
		repeat (40)
			op(1'($urandom), ROW_W'($urandom % 4), 2'($urandom), 0);
		$display("test random traffic done");
		// the master now supplies the output pair, in phase with the input pair
		oc_on = 1'b1;
		repeat (8)
			op(1'($urandom), ROW_W'($urandom % 4), 2'($urandom), 0);
		repeat (4) m.nop();
		chk("reads_left", 0, exq.size() + rd_at.size());
		$display("test output clock done");
		wait (cyc > rel + 1030);
		$display("test calibration done");
		wrap_up();
	end
endmodule // test_ddr_burst4_sram_bus
